// [core/fdsi_drive_if.sv]
// Drive-side pin logic of the floppy controller with a write byte FIFO.
//
// Function
// - Side select pin is high for side 0 and low for side 1.
// - Step direction pin is high for outward and low for inward motion.
// - One active-low step pulse is issued for each track-to-track move.
// - Status bit 7 of the 3F7H byte is the inverted media change input.
// - Two active-low open-drain drive selects, only the chosen one asserted.
// - Two active-low open-drain motor enables, each driven independently.
// - While write protect is asserted, writes are ignored and never start.
// - Two density outputs encode drive and media per a configured mode.
// - Write gate goes active just before write data and holds through it.
// - Each falling edge of write data makes one flux transition.
// - Each falling edge of read data counts as one flux transition.
`timescale 1ns/100ps
`include "fdsi_regs.svh"
module fdsi_drive_if import fdsi_pkg::*; #(
    parameter int unsigned STEP_RATE_CYC = `FDSI_STEP_RATE_CYC,
    parameter int FIFO_DEPTH = `FDSI_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic drive_sel,
    input wire logic drive_en,
    input wire logic [1:0] motor_on,
    input wire logic side_sel,
    input wire logic [1:0] data_rate,
    input wire logic [1:0] density_mode,
    input wire logic seek_start,
    input wire logic seek_outward,
    input wire logic [7:0] seek_count,
    output logic seek_busy,
    output logic at_track_zero,
    input wire logic wr_start,
    input wire logic wr_end,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic wr_active,
    output logic wr_refused,
    output logic wr_underrun,
    output logic rd_flux_pulse,
    output logic index_pulse,
    output logic write_protected,
    output logic [7:0] status_3f7,
    input wire logic media_changed_n,
    input wire logic write_protect_n,
    input wire logic track_zero_n,
    input wire logic index_hole_n,
    input wire logic read_flux_n,
    output logic side_select_n_o,
    output logic side_select_n_oe,
    output logic step_direction_n_o,
    output logic step_direction_n_oe,
    output logic step_pulse_n_o,
    output logic step_pulse_n_oe,
    output logic [1:0] drive_select_n_o,
    output logic [1:0] drive_select_n_oe,
    output logic [1:0] motor_enable_n_o,
    output logic [1:0] motor_enable_n_oe,
    output logic density_out0_o,
    output logic density_out0_oe,
    output logic density_out1_o,
    output logic density_out1_oe,
    output logic write_gate_n_o,
    output logic write_gate_n_oe,
    output logic write_flux_n_o,
    output logic write_flux_n_oe
);
    localparam logic [15:0] CELL = 16'(`FDSI_BIT_CELL_CYC);
    localparam logic [15:0] WPULSE = 16'(`FDSI_WR_PULSE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Drive, motor, side and density levels. A side or density level of 1
    // means the open-drain driver is released and the pull-up holds it high;
    // a drive or motor level of 1 means the driver pulls the pin low.

    logic side_q, side_d;
    logic [1:0] sel_q, sel_d, mtr_q, mtr_d, den_q, den_d;

    for (genvar i = 0; i < 2; i++) begin : g_drive
        assign sel_d[i] = drive_en && (drive_sel == 1'(i));
        assign mtr_d[i] = motor_on[i];
    end

    always_comb begin
        side_d = ~side_sel;
        case (density_mode)
            2'd0: den_d = data_rate;
            2'd1: den_d = ~data_rate;
            2'd2: den_d = {data_rate[1] ^ drive_sel, data_rate[0]};
            default: den_d = 2'b11;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            side_q <= 1'b1;
            sel_q <= 2'b00;
            mtr_q <= 2'b00;
            den_q <= 2'b11;
        end else if (clk_en) begin
            side_q <= side_d;
            sel_q <= sel_d;
            mtr_q <= mtr_d;
            den_q <= den_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive inputs. Pins are taken as already synchronous to clk.

    logic rdp_q, rdp_d, idxp_q, idxp_d, rdpl_q, rdpl_d, idxpl_q, idxpl_d;
    logic tz_q, tz_d, wp_q, wp_d, chg_q, chg_d;

    always_comb begin
        rdp_d = read_flux_n;
        idxp_d = index_hole_n;
        rdpl_d = rdp_q && !read_flux_n;
        idxpl_d = idxp_q && !index_hole_n;
        tz_d = !track_zero_n;
        wp_d = !write_protect_n;
        chg_d = !media_changed_n;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdp_q <= 1'b1;
            idxp_q <= 1'b1;
            rdpl_q <= 1'b0;
            idxpl_q <= 1'b0;
            tz_q <= 1'b0;
            wp_q <= 1'b0;
            chg_q <= 1'b0;
        end else if (clk_en) begin
            rdp_q <= rdp_d;
            idxp_q <= idxp_d;
            rdpl_q <= rdpl_d;
            idxpl_q <= idxpl_d;
            tz_q <= tz_d;
            wp_q <= wp_d;
            chg_q <= chg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Head seek.

    logic dir_out, step_act;

    fdsi_stepper #(.RATE_CYC(STEP_RATE_CYC)) u_step (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(seek_start),
        .outward(seek_outward),
        .count(seek_count),
        .track_zero(tz_q),
        .busy(seek_busy),
        .dir_outward(dir_out),
        .pulse_act(step_act)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write path: bytes queue in the FIFO and leave MSB first, one bit
    // cell each; a one bit pulls the flux pin low for a short pulse.

    fdsi_fifo_if #(.WIDTH(8)) wq ();

    fdsi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .port(wq.mp_fifo)
    );

    fdsi_wr_st_t ws_q, ws_d;
    logic [15:0] cell_q, cell_d, fl_q, fl_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bits_q, bits_d;
    logic end_q, end_d, ref_q, ref_d, und_q, und_d, need_byte;

    assign wq.push_valid = wr_valid && (ws_q != WR_IDLE);
    assign wq.push_data = wr_data;
    assign wr_ready = wq.push_ready && (ws_q != WR_IDLE);

    always_comb begin
        ws_d = ws_q;
        cell_d = (cell_q > 16'd1) ? cell_q - 16'd1 : 16'd1;
        fl_d = (fl_q != 16'd0) ? fl_q - 16'd1 : 16'd0;
        sh_d = sh_q;
        bits_d = bits_q;
        end_d = end_q || wr_end;
        ref_d = 1'b0;
        und_d = 1'b0;
        wq.pop_ready = 1'b0;
        need_byte = (cell_q <= 16'd1) &&
            ((ws_q == WR_LEAD) || (bits_q <= 4'd1));
        case (ws_q)
            WR_IDLE: begin
                // Stale bytes from an aborted write are flushed here.
                wq.pop_ready = 1'b1;
                end_d = 1'b0;
                fl_d = 16'd0;
                if (wr_start) begin
                    if (!write_protect_n) begin
                        ref_d = 1'b1;
                    end else begin
                        ws_d = WR_LEAD;
                        cell_d = CELL;
                    end
                end
            end
            WR_LEAD, WR_SHIFT: begin
                if (!write_protect_n) begin
                    ws_d = WR_IDLE;
                    fl_d = 16'd0;
                end else if (need_byte) begin
                    cell_d = CELL;
                    if (wq.pop_valid) begin
                        wq.pop_ready = 1'b1;
                        sh_d = wq.pop_data;
                        bits_d = 4'd8;
                        fl_d = wq.pop_data[7] ? WPULSE : 16'd0;
                        ws_d = WR_SHIFT;
                    end else begin
                        und_d = !end_q;
                        ws_d = WR_IDLE;
                    end
                end else if (cell_q <= 16'd1) begin
                    cell_d = CELL;
                    sh_d = {sh_q[6:0], 1'b0};
                    bits_d = bits_q - 4'd1;
                    fl_d = sh_q[6] ? WPULSE : 16'd0;
                end
            end
            default: ws_d = WR_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ws_q <= WR_IDLE;
            cell_q <= 16'd1;
            fl_q <= 16'd0;
            sh_q <= 8'h00;
            bits_q <= 4'd0;
            end_q <= 1'b0;
            ref_q <= 1'b0;
            und_q <= 1'b0;
        end else if (clk_en) begin
            ws_q <= ws_d;
            cell_q <= cell_d;
            fl_q <= fl_d;
            sh_q <= sh_d;
            bits_q <= bits_d;
            end_q <= end_d;
            ref_q <= ref_d;
            und_q <= und_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. Every open-drain pin only ever pulls low.

    assign at_track_zero = tz_q;
    assign wr_active = (ws_q != WR_IDLE);
    assign wr_refused = ref_q;
    assign wr_underrun = und_q;
    assign rd_flux_pulse = rdpl_q;
    assign index_pulse = idxpl_q;
    assign write_protected = wp_q;
    assign status_3f7 = {chg_q, 7'h00};
    assign side_select_n_o = 1'b0;
    assign side_select_n_oe = ~side_q;
    assign step_direction_n_o = 1'b0;
    assign step_direction_n_oe = ~dir_out;
    assign step_pulse_n_o = 1'b0;
    assign step_pulse_n_oe = step_act;
    assign drive_select_n_o = 2'b00;
    assign drive_select_n_oe = sel_q;
    assign motor_enable_n_o = 2'b00;
    assign motor_enable_n_oe = mtr_q;
    assign density_out0_o = 1'b0;
    assign density_out0_oe = ~den_q[0];
    assign density_out1_o = 1'b0;
    assign density_out1_oe = ~den_q[1];
    assign write_gate_n_o = 1'b0;
    assign write_gate_n_oe = (ws_q != WR_IDLE);
    assign write_flux_n_o = 1'b0;
    assign write_flux_n_oe = (fl_q != 16'd0) && (ws_q != WR_IDLE);

    property p_side;
        @(posedge clk) disable iff (sys_rst)
        clk_en |=> (side_select_n_oe == $past(side_sel));
    endproperty
    a_side: assert property (p_side)
        else $error("side select level does not follow the side request");

    property p_one_drive;
        @(posedge clk) disable iff (sys_rst)
        clk_en |=> ($onehot0(drive_select_n_oe) &&
            drive_select_n_oe == ($past(drive_en) ?
            ($past(drive_sel) ? 2'b10 : 2'b01) : 2'b00));
    endproperty
    a_one_drive: assert property (p_one_drive)
        else $error("drive select does not match the chosen drive");

    property p_motor;
        @(posedge clk) disable iff (sys_rst)
        clk_en |=> (motor_enable_n_oe == $past(motor_on));
    endproperty
    a_motor: assert property (p_motor)
        else $error("motor enable does not follow its request");

    property p_protect;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !write_protect_n && !wr_active && wr_start)
            |=> (wr_refused && !write_gate_n_oe) ##1 !write_gate_n_oe;
    endproperty
    a_protect: assert property (p_protect)
        else $error("write started on a protected medium");

    property p_flux_in_gate;
        @(posedge clk) disable iff (sys_rst)
        write_flux_n_oe |-> write_gate_n_oe && $past(write_gate_n_oe);
    endproperty
    a_flux_in_gate: assert property (p_flux_in_gate)
        else $error("write data pulse outside the write gate");

    property p_flux_pulse;
        @(posedge clk) disable iff (sys_rst)
        ($rose(write_flux_n_oe) && clk_en) |-> write_flux_n_oe [*8];
    endproperty
    a_flux_pulse: assert property (p_flux_pulse)
        else $error("write flux pulse too short");

    property p_read_edge;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && rdp_q && !read_flux_n) |=> rd_flux_pulse ##1
            (!$past(clk_en) || !rd_flux_pulse);
    endproperty
    a_read_edge: assert property (p_read_edge)
        else $error("read flux edge not reported once");

    property p_status;
        @(posedge clk) disable iff (sys_rst)
        clk_en |=> (status_3f7[`FDSI_STATUS_CHG_BIT] ==
            !$past(media_changed_n));
    endproperty
    a_status: assert property (p_status)
        else $error("media change status bit wrong");
endmodule : fdsi_drive_if

// [core/fdsi_fifo.sv]
// Byte FIFO whose head word is held in a register.
`timescale 1ns/100ps
`include "fdsi_regs.svh"
module fdsi_fifo #(
    parameter int WIDTH = `FDSI_FIFO_WIDTH,
    parameter int DEPTH = `FDSI_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    fdsi_fifo_if.mp_fifo port
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] head_q, head_d;
    logic do_push, do_pop;

    assign port.push_ready = (cnt_q != CW'(DEPTH));
    assign port.pop_valid = (cnt_q != '0);
    assign port.pop_data = head_q;

    always_comb begin
        do_push = port.push_valid && port.push_ready;
        do_pop = port.pop_valid && port.pop_ready;
        wp_d = do_push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = do_pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = CW'(cnt_q + CW'(do_push) - CW'(do_pop));
        // A word written into the new head slot bypasses the array.
        head_d = (do_push && wp_q == rp_d) ? port.push_data : mem_q[rp_d];
    end

    always_ff @(posedge clk) begin
        if (clk_en && do_push) begin
            mem_q[wp_q] <= port.push_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            head_q <= '0;
        end else if (clk_en) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            head_q <= head_d;
        end
    end
endmodule : fdsi_fifo

// [core/fdsi_fifo_if.sv]
// Valid/ready carrier between the write path and its byte FIFO.
`timescale 1ns/100ps
interface fdsi_fifo_if #(parameter int WIDTH = 8);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport mp_fifo (input push_valid, push_data, pop_ready,
                     output push_ready, pop_valid, pop_data);
    modport mp_user (output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
endinterface : fdsi_fifo_if

// [core/fdsi_pkg.sv]
// Types shared by the floppy drive signal interface modules.
package fdsi_pkg;
    typedef enum logic [3:0] {
        STEP_IDLE = 4'b0001,
        STEP_SETTLE = 4'b0010,
        STEP_PULSE = 4'b0100,
        STEP_GAP = 4'b1000
    } fdsi_step_st_t;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_LEAD = 3'b010,
        WR_SHIFT = 3'b100
    } fdsi_wr_st_t;
endpackage : fdsi_pkg

// [core/fdsi_regs.svh]
// Constants for the floppy drive signal interface: sizes, a status bit and timing counts.
`ifndef FDSI_REGS_SVH
`define FDSI_REGS_SVH
`define FDSI_CLK_MHZ 100
`define FDSI_FIFO_WIDTH 8
`define FDSI_FIFO_DEPTH 16
`define FDSI_STATUS_CHG_BIT 7
`define FDSI_STEP_PULSE_NS 1000
`define FDSI_STEP_PULSE_CYC ((`FDSI_STEP_PULSE_NS*`FDSI_CLK_MHZ+999)/1000)
`define FDSI_DIR_SETTLE_NS 500
`define FDSI_DIR_SETTLE_CYC ((`FDSI_DIR_SETTLE_NS*`FDSI_CLK_MHZ+999)/1000)
`define FDSI_STEP_RATE_NS 3000000
`define FDSI_STEP_RATE_CYC ((`FDSI_STEP_RATE_NS*`FDSI_CLK_MHZ)/1000)
`define FDSI_BIT_CELL_NS 2000
`define FDSI_BIT_CELL_CYC ((`FDSI_BIT_CELL_NS*`FDSI_CLK_MHZ)/1000)
`define FDSI_WR_PULSE_NS 200
`define FDSI_WR_PULSE_CYC ((`FDSI_WR_PULSE_NS*`FDSI_CLK_MHZ+999)/1000)
`endif

// [core/fdsi_stepper.sv]
// Head seek sequencer: direction settle, step pulse and step spacing.
`timescale 1ns/100ps
`include "fdsi_regs.svh"
module fdsi_stepper import fdsi_pkg::*; #(
    parameter int unsigned RATE_CYC = `FDSI_STEP_RATE_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic outward,
    input wire logic [7:0] count,
    input wire logic track_zero,
    output logic busy,
    output logic dir_outward,
    output logic pulse_act
);
    localparam logic [31:0] SETTLE = 32'(`FDSI_DIR_SETTLE_CYC);
    localparam logic [31:0] PULSE = 32'(`FDSI_STEP_PULSE_CYC);
    localparam logic [31:0] GAP = 32'(RATE_CYC) - PULSE;
    fdsi_step_st_t st_q, st_d;
    logic [31:0] tmr_q, tmr_d;
    logic [7:0] left_q, left_d;
    logic dir_q, dir_d;

    assign busy = (st_q != STEP_IDLE);
    assign dir_outward = dir_q;
    assign pulse_act = (st_q == STEP_PULSE);

    always_comb begin
        st_d = st_q;
        tmr_d = (tmr_q > 32'd1) ? tmr_q - 32'd1 : 32'd1;
        left_d = left_q;
        dir_d = dir_q;
        case (st_q)
            STEP_IDLE: begin
                if (start && count != 8'h00) begin
                    dir_d = outward;
                    left_d = count;
                    tmr_d = SETTLE;
                    st_d = STEP_SETTLE;
                end
            end
            STEP_SETTLE: begin
                if (tmr_q <= 32'd1) begin
                    // Stepping outward past the outermost track is refused.
                    if (dir_q && track_zero) begin
                        st_d = STEP_IDLE;
                    end else begin
                        tmr_d = PULSE;
                        st_d = STEP_PULSE;
                    end
                end
            end
            STEP_PULSE: begin
                if (tmr_q <= 32'd1) begin
                    left_d = left_q - 8'h01;
                    tmr_d = GAP;
                    st_d = STEP_GAP;
                end
            end
            STEP_GAP: begin
                if (tmr_q <= 32'd1) begin
                    st_d = (left_q == 8'h00) ? STEP_IDLE : STEP_SETTLE;
                    tmr_d = SETTLE;
                end
            end
            default: st_d = STEP_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= STEP_IDLE;
            tmr_q <= 32'd1;
            left_q <= 8'h00;
            dir_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            left_q <= left_d;
            dir_q <= dir_d;
        end
    end

    property p_dir_stable;
        @(posedge clk) disable iff (sys_rst)
        (st_q == STEP_PULSE) |=> $stable(dir_q);
    endproperty
    a_dir_stable: assert property (p_dir_stable)
        else $error("step direction moved during a step pulse");

    property p_pulse_width;
        @(posedge clk) disable iff (sys_rst)
        ($rose(pulse_act) && clk_en) |-> pulse_act [*8];
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("step pulse shorter than expected");

    property p_dir_load;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && st_q == STEP_IDLE && start && count != 8'h00)
            |=> (dir_q == $past(outward));
    endproperty
    a_dir_load: assert property (p_dir_load)
        else $error("step direction not taken from the request");
endmodule : fdsi_stepper

// [testbench/fdsi_drive_if_test.sv]
// Self-checking bench for the drive-side pin logic and its write FIFO.
`timescale 1ns/100ps
module fdsi_drive_if_test import fdsi_pkg::*;;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    logic drive_sel = 1'b0, drive_en = 1'b0, side_sel = 1'b0;
    logic [1:0] motor_on = 2'h0, data_rate = 2'h0, density_mode = 2'h0;
    logic seek_start = 1'b0, seek_outward = 1'b0, wr_start = 1'b0;
    logic wr_end = 1'b0, wr_valid = 1'b0, media_changed_n = 1'b1;
    logic read_flux_n = 1'b1, protect = 1'b0;
    logic [7:0] seek_count = 8'h00, wr_data = 8'h00, status_3f7;
    logic seek_busy, at_track_zero, wr_ready, wr_active, wr_refused;
    logic rd_flux_pulse, index_pulse, write_protected, wr_underrun;
    logic write_protect_n, track_zero_n, index_hole_n;
    logic side_select_n_oe, step_direction_n_oe, step_pulse_n_oe;
    logic [1:0] drive_select_n_oe, motor_enable_n_oe;
    logic density_out0_oe, density_out1_oe, write_gate_n_oe, write_flux_n_oe;
    int err_count = 0, n_checks = 0, n_flux = 0, n_rd = 0, n_idx = 0;
    int track, n_index, dir_err, n_acc, idx0;
    // Row: {sel, en, motor[1:0], side, chg_n, rate[1:0], mode[1:0]}, then
    // expected {ds_oe[1:0], mtr_oe[1:0], side_oe, st7, den1_oe, den0_oe}.
    logic [17:0] rows [6] = '{18'h1_5053, 18'h3_a5ad, 18'h2_da33,
                              18'h1_2f4c, 18'h3_1881, 18'h0_1a01};

    fdsi_drive_if #(.STEP_RATE_CYC(200)) i_dut (
        .clk, .sys_rst, .clk_en, .drive_sel, .drive_en, .motor_on, .side_sel,
        .data_rate, .density_mode, .seek_start, .seek_outward, .seek_count,
        .seek_busy, .at_track_zero, .wr_start, .wr_end, .wr_valid, .wr_ready,
        .wr_data, .wr_active, .wr_refused, .wr_underrun, .rd_flux_pulse,
        .index_pulse, .write_protected, .status_3f7, .media_changed_n,
        .write_protect_n, .track_zero_n, .index_hole_n, .read_flux_n,
        .side_select_n_o(), .side_select_n_oe, .step_direction_n_o(),
        .step_direction_n_oe, .step_pulse_n_o(), .step_pulse_n_oe,
        .drive_select_n_o(), .drive_select_n_oe, .motor_enable_n_o(),
        .motor_enable_n_oe, .density_out0_o(), .density_out0_oe,
        .density_out1_o(), .density_out1_oe, .write_gate_n_o(),
        .write_gate_n_oe, .write_flux_n_o(), .write_flux_n_oe);

    fdsi_drive_model i_drive (.clk, .step_pin(~step_pulse_n_oe),
        .dir_pin(~step_direction_n_oe), .protect, .track_zero_n,
        .index_hole_n, .write_protect_n, .track, .n_index, .dir_err);

    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic wait_idle(input int lim);
        int k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((seek_busy !== 1'b0 || wr_active !== 1'b0) && k < lim);
        check(k < lim, 1'b1);
    endtask : wait_idle

    // A second start in mid-sequence must leave the step count untouched.
    task automatic seek(input logic outw, input logic [7:0] n);
        @(posedge clk);
        seek_start <= 1'b1;
        seek_outward <= outw;
        seek_count <= n;
        @(posedge clk);
        seek_start <= 1'b0;
        @(negedge clk);
        check(seek_busy, 1'b1);
        check(step_direction_n_oe, !outw);
        @(posedge clk);
        seek_start <= 1'b1;
        @(posedge clk);
        seek_start <= 1'b0;
        wait_idle(6000);
    endtask : seek
    ////////////////////////////////////////////////////////////////////////
    always @(posedge write_flux_n_oe) begin
        n_flux++;
        check(write_gate_n_oe, 1'b1);
    end
    always @(posedge clk) begin
        if (rd_flux_pulse === 1'b1) n_rd <= n_rd + 1;
        if (index_pulse === 1'b1) n_idx <= n_idx + 1;
    end

    initial begin
        #500000;
        err_count++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        check({side_select_n_oe, step_pulse_n_oe, drive_select_n_oe,
               motor_enable_n_oe, density_out0_oe, density_out1_oe,
               write_gate_n_oe, write_flux_n_oe, status_3f7, seek_busy,
               wr_ready}, 32'h0000_0000);
        check(step_direction_n_oe, 1'b1);
        sys_rst <= 1'b0;
        idx0 = n_index;
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge clk);
            {drive_sel, drive_en, motor_on, side_sel, media_changed_n,
             data_rate, density_mode} <= rows[i][17:8];
            repeat (4) @(posedge clk);
            @(negedge clk);
            check({drive_select_n_oe, motor_enable_n_oe, side_select_n_oe,
                   status_3f7[7], density_out1_oe, density_out0_oe},
                  rows[i][7:0]);
            check(status_3f7[6:0], 7'h00);
        end
        $display("pin table test done");
        // A frozen clock enable must hold the side level off a new request.
        @(posedge clk);
        clk_en <= 1'b0;
        side_sel <= 1'b1;
        repeat (3) @(posedge clk);
        check(side_select_n_oe, 1'b0);
        clk_en <= 1'b1;
        $display("clock enable test done");
        seek(1'b0, 8'h03);
        check(track, 8);
        seek(1'b1, 8'h0a);
        check(track, 0);
        check(at_track_zero, 1'b1);
        check(dir_err, 0);
        $display("seek test done");
        protect <= 1'b1;
        repeat (3) @(posedge clk);
        wr_start <= 1'b1;
        @(posedge clk);
        wr_start <= 1'b0;
        @(negedge clk);
        check({wr_refused, wr_active, write_protected}, 3'h5);
        @(negedge clk);
        check({wr_refused, write_gate_n_oe, wr_ready}, 3'h0);
        protect <= 1'b0;
        repeat (3) @(posedge clk);
        wr_start <= 1'b1;
        @(posedge clk);
        wr_start <= 1'b0;
        n_flux = 0;
        @(negedge clk);
        check(write_gate_n_oe, 1'b1);
        // Fill until the buffer refuses; the head byte waits for cell one.
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= 8'ha5;
        n_acc = 0;
        @(negedge clk);
        while (wr_ready === 1'b1 && n_acc < 40) begin
            n_acc++;
            @(negedge clk);
        end
        @(posedge clk);
        wr_valid <= 1'b0;
        wr_end <= 1'b1;
        @(posedge clk);
        wr_end <= 1'b0;
        check(n_acc, 16);
        wait_idle(40000);
        check(n_flux, 64);
        check(write_gate_n_oe, 1'b0);
        check(wr_underrun, 1'b0);
        $display("write test done");
        // One byte and no end mark: the buffer runs dry and the gate drops.
        n_flux = 0;
        @(posedge clk);
        wr_start <= 1'b1;
        @(posedge clk);
        wr_start <= 1'b0;
        wr_valid <= 1'b1;
        wr_data <= 8'h80;
        @(posedge clk);
        wr_valid <= 1'b0;
        wait_idle(3000);
        check(wr_underrun, 1'b1);
        check(n_flux, 1);
        $display("underrun test done");
        repeat (5) begin
            @(posedge clk);
            read_flux_n <= 1'b0;
            repeat (3) @(posedge clk);
            read_flux_n <= 1'b1;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        check(n_rd, 5);
        @(posedge index_hole_n);
        repeat (4) @(posedge clk);
        check(n_idx, n_index - idx0);
        $display("flux and index test done");
        complete_run();
    end
endmodule : fdsi_drive_if_test

// [testbench/fdsi_drive_model.sv]
// Floppy drive model: head position, track zero, index hole and protect.
`timescale 1ns/100ps
module fdsi_drive_model #(
    parameter int START_TRACK = 5,
    parameter int INDEX_PER = 1000
) (
    input wire logic clk,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic protect,
    output logic track_zero_n,
    output logic index_hole_n,
    output logic write_protect_n,
    output int track,
    output int n_index,
    output int dir_err
);
    int cnt = 0;
    logic step_q = 1'b1;
    logic dir_q = 1'b0;
    initial begin
        track = START_TRACK;
        n_index = 0;
        dir_err = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // The head moves on the falling edge of the step pin, as a real drive.
    always @(posedge clk) begin
        step_q <= step_pin;
        dir_q <= dir_pin;
        // A direction change while the step pin is low would be ambiguous.
        if (!step_pin && dir_pin !== dir_q) begin
            dir_err <= dir_err + 1;
        end
        if (step_q && !step_pin) begin
            if (dir_pin) track <= (track > 0) ? track - 1 : 0;
            else track <= track + 1;
        end
        cnt <= (cnt == INDEX_PER - 1) ? 0 : cnt + 1;
        if (cnt == 0) n_index <= n_index + 1;
    end
    assign track_zero_n = (track != 0);
    assign index_hole_n = (cnt >= 10);
    assign write_protect_n = !protect;
endmodule : fdsi_drive_model
